// *** src/rsw_spi_port.sv ***
// Serial register and scratch RAM access port of the clock calendar
// Summary of operation
// - Stamp date holds tens digit bits 5-4, ones bits 3-0; bits 7-6 zero.
// - Stamp month bits 7-5 hold a user-defined weekday 1 to 7.
// - Stamp month bit 4 is month tens, bits 3-0 month ones.
// - Power-down date at 0x1A, power-up date at 0x1E, read/write, reset zero.
// - Power-down month at 0x1B, power-up month at 0x1F, read/write, reset zero.
// - Scratch RAM survives supply loss only with backup present and enabled.
// - Clock registers and RAM share one read and one write instruction.
// - Clock registers sit at 0x00-0x1F, scratch RAM at 0x20-0x5F.
// - Scratch RAM is 64 bytes, one for each address 0x20-0x5F.
// - RAM accesses complete even while clock registers update.
// - Power-on reset leaves scratch RAM contents untouched.
// - All serial accesses are refused while running from backup supply.
// - Any number of data bytes may follow in one write command.
// - Pointer wraps 0x1F to 0x00 and 0x5F to 0x20.
// - Each byte is stored as soon as its eighth bit arrives.
// - Read: instruction and address, then data shifts out while clocked.
// - Read pointer advances after each byte with the same wraparound.
// - New stamps are logged only after the power-loss flag was cleared.
// - Clearing the power-loss flag zeroes all timestamp registers.
`include "rsw_consts.svh"
`default_nettype none
module rsw_spi_port
    import rsw_pkg::*;
#(
    parameter logic [7:0] CMD_READ  = `RSW_CMD_READ,
    parameter logic [7:0] CMD_WRITE = `RSW_CMD_WRITE,
    parameter int         RAM_BYTES = 64
) (
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    input  wire logic          clk_en,
    input  wire logic          cs_n,
    input  wire logic          sck,
    input  wire logic          si,
    output logic               so,
    output logic               so_oe,
    input  wire logic          on_backup,
    input  wire logic          backup_present,
    input  wire logic          osc_running,
    input  wire rsw_stamp_type now_stamp,
    output logic               backup_input_enable,
    output logic               power_loss_flag
);

    // Reset release and pin synchronisers
    logic [1:0]    rst_sync;
    logic          rst_n;
    logic [5:0]    pin_meta;
    logic [5:0]    pin_s;
    logic          sck_q;
    logic          bk_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else if (clk_en) begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= `RSW_PIN_RESET;
            pin_s    <= `RSW_PIN_RESET;
            sck_q    <= 1'b0;
            bk_q     <= 1'b0;
        end else if (clk_en) begin
            pin_meta <= {osc_running, backup_present, on_backup, si, sck, cs_n};
            pin_s    <= pin_meta;
            sck_q    <= pin_s[`RSW_PIN_SCK];
            bk_q     <= pin_s[`RSW_PIN_BK];
        end
    end

    // Link decode
    wire logic on_bk      = pin_s[`RSW_PIN_BK];
    wire logic cs_active  = !pin_s[`RSW_PIN_CS] && !on_bk;
    wire logic sck_rise   = pin_s[`RSW_PIN_SCK] && !sck_q;
    wire logic sck_fall   = !pin_s[`RSW_PIN_SCK] && sck_q;
    wire logic pd_evt     = on_bk && !bk_q;
    wire logic pu_evt     = !on_bk && bk_q;

    rsw_state_type state;
    rsw_state_type next_state;
    logic [2:0]    bit_cnt;
    logic [6:0]    rx_sh;
    logic [7:0]    tx_sh;
    logic [7:0]    ptr;
    logic          is_read;
    logic          stamp_armed;
    logic [4:0]    flags;
    logic [7:0]    clk_regs [0:31];
    logic [7:0]    ram [0:RAM_BYTES-1];

    wire logic [7:0] rx_byte = {rx_sh, pin_s[`RSW_PIN_SI]};
    wire logic       rx_done = sck_rise && cs_active && (bit_cnt == `RSW_BIT_LAST);
    wire logic       wr_fire = rx_done && (state == RSW_DATA) && !is_read;
    wire logic       rd_next = rx_done && (state == RSW_DATA) && is_read;

    function automatic logic in_clk(input logic [7:0] a);
        return a <= `RSW_CLK_LAST;
    endfunction

    function automatic logic in_ram(input logic [7:0] a);
        return (a >= `RSW_RAM_FIRST) && (a <= `RSW_RAM_LAST);
    endfunction

    // Each block wraps onto itself; addresses above both blocks just count on
    function automatic logic [7:0] next_addr(input logic [7:0] a);
        if (a == `RSW_CLK_LAST) begin
            return `RSW_CLK_FIRST;
        end else if (a == `RSW_RAM_LAST) begin
            return `RSW_RAM_FIRST;
        end
        return 8'(a + 8'h01);
    endfunction

    function automatic logic [7:0] wr_mask(input logic [7:0] a);
        if ((a == `RSW_PD_DATE_ADDR) || (a == `RSW_PU_DATE_ADDR)) begin
            return `RSW_DATE_MASK;
        end else if ((a == `RSW_PD_MONTH_ADDR) || (a == `RSW_PU_MONTH_ADDR)) begin
            return `RSW_MONTH_MASK;
        end
        return `RSW_FULL_MASK;
    endfunction

    // Shared read decode for the first byte and every following one
    function automatic logic [7:0] read_byte(input logic [7:0] a);
        logic [7:0] r;
        r = `RSW_ZERO_BYTE;
        if (a == `RSW_FLAGS_ADDR) begin
            r = {2'b00, pin_s[`RSW_PIN_OSC], flags};
        end else if (in_clk(a)) begin
            r = clk_regs[a[4:0]];
        end else if (in_ram(a)) begin
            r = ram[6'(a - `RSW_RAM_FIRST)];
        end
        return r;
    endfunction

    // Instruction decode: only the shared pair is served here, others are skipped
    always_comb begin
        next_state = state;
        case (state)
            RSW_IDLE: begin
                if (cs_active) begin
                    next_state = RSW_CMD;
                end
            end
            RSW_CMD: begin
                if (rx_done) begin
                    if ((rx_byte == CMD_READ) || (rx_byte == CMD_WRITE)) begin
                        next_state = RSW_ADDR;
                    end else begin
                        next_state = RSW_SKIP;
                    end
                end
            end
            RSW_ADDR: begin
                if (rx_done) begin
                    next_state = RSW_DATA;
                end
            end
            RSW_DATA: next_state = RSW_DATA;
            RSW_SKIP: next_state = RSW_SKIP;
            default:  next_state = RSW_IDLE;
        endcase
        if (!cs_active) begin
            next_state = RSW_IDLE;
        end
    end

    // Serial engine: sample on rising SCK, shift out on falling SCK
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= RSW_IDLE;
            bit_cnt <= `RSW_BIT_ZERO;
            rx_sh   <= 7'h00;
            tx_sh   <= 8'h00;
            ptr     <= 8'h00;
            is_read <= 1'b0;
            so      <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            if (!cs_active) begin
                bit_cnt <= `RSW_BIT_ZERO;
            end else if (sck_rise) begin
                bit_cnt <= 3'(bit_cnt + 3'h1);
                rx_sh   <= rx_byte[6:0];
            end
            if (rx_done && (state == RSW_CMD)) begin
                is_read <= (rx_byte == CMD_READ);
            end
            if (rx_done && (state == RSW_ADDR)) begin
                ptr   <= rx_byte;
                tx_sh <= read_byte(rx_byte);
            end else if (wr_fire) begin
                ptr <= next_addr(ptr);
            end else if (rd_next) begin
                ptr   <= next_addr(ptr);
                tx_sh <= read_byte(next_addr(ptr));
            end else if (sck_fall && cs_active && is_read && (state == RSW_DATA)) begin
                so    <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    assign so_oe = cs_active && is_read && (state == RSW_DATA);

    // Power flags and timestamp logging
    wire logic flags_wr  = wr_fire && (ptr == `RSW_FLAGS_ADDR);
    wire logic sw_clear  = flags_wr && !rx_byte[`RSW_LOSS_BIT] && flags[`RSW_LOSS_BIT];
    wire logic stamp_clr = sw_clear && !pd_evt;
    wire logic log_down  = pd_evt && !flags[`RSW_LOSS_BIT] && flags[`RSW_BKEN_BIT];
    wire logic log_up    = pu_evt && stamp_armed;

    assign backup_input_enable = flags[`RSW_BKEN_BIT];
    assign power_loss_flag     = flags[`RSW_LOSS_BIT];

    // A new power-down event wins over a clear arriving in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags       <= `RSW_FLAGS_RESET;
            stamp_armed <= 1'b0;
        end else if (clk_en) begin
            if (flags_wr) begin
                flags[`RSW_BKEN_BIT:0] <= rx_byte[`RSW_BKEN_BIT:0];
            end
            if (log_down) begin
                flags[`RSW_LOSS_BIT] <= 1'b1;
                stamp_armed          <= 1'b1;
            end else if (stamp_clr) begin
                flags[`RSW_LOSS_BIT] <= 1'b0;
                stamp_armed          <= 1'b0;
            end else if (log_up) begin
                stamp_armed <= 1'b0;
            end
        end
    end

    // Clock register file, timestamps included
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                clk_regs[i] <= `RSW_STAMP_RESET;
            end
        end else if (clk_en) begin
            if (wr_fire && in_clk(ptr) && (ptr != `RSW_FLAGS_ADDR)) begin
                clk_regs[ptr[4:0]] <= rx_byte & wr_mask(ptr);
            end
            if (log_down) begin
                clk_regs[5'(`RSW_PD_DATE_ADDR)]  <= now_stamp.date & `RSW_DATE_MASK;
                clk_regs[5'(`RSW_PD_MONTH_ADDR)] <= now_stamp.month;
            end else if (log_up) begin
                clk_regs[5'(`RSW_PU_DATE_ADDR)]  <= now_stamp.date & `RSW_DATE_MASK;
                clk_regs[5'(`RSW_PU_MONTH_ADDR)] <= now_stamp.month;
            end else if (stamp_clr) begin
                clk_regs[5'(`RSW_PD_DATE_ADDR)]  <= `RSW_STAMP_RESET;
                clk_regs[5'(`RSW_PD_MONTH_ADDR)] <= `RSW_STAMP_RESET;
                clk_regs[5'(`RSW_PU_DATE_ADDR)]  <= `RSW_STAMP_RESET;
                clk_regs[5'(`RSW_PU_MONTH_ADDR)] <= `RSW_STAMP_RESET;
            end
        end
    end

    // Scratch RAM has no reset; losing supply without backup loses its contents
    wire logic ram_lost = on_bk && !(pin_s[`RSW_PIN_BP] && flags[`RSW_BKEN_BIT]);

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (ram_lost) begin
                for (int i = 0; i < RAM_BYTES; i++) begin
                    ram[i] <= `RSW_ZERO_BYTE;
                end
            end else if (wr_fire && in_ram(ptr)) begin
                ram[6'(ptr - `RSW_RAM_FIRST)] <= rx_byte;
            end
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_addr_taken;
        clk_en && rx_done && (state == RSW_ADDR);
    endsequence

    sequence s_byte_stored;
        clk_en && wr_fire;
    endsequence

    date_pad_zero_a: assert property (clk_regs[5'(`RSW_PD_DATE_ADDR)][7:6] == 2'b00 &&
            clk_regs[5'(`RSW_PU_DATE_ADDR)][7:6] == 2'b00)
        else $error("stamp date upper bits not zero");

    ram_commit_a: assert property (s_byte_stored ##0 (in_ram(ptr) && !ram_lost)
            |=> ram[$past(6'(ptr - `RSW_RAM_FIRST))] == $past(rx_byte))
        else $error("ram byte not stored on eighth bit");

    ptr_wrap_a: assert property (s_byte_stored ##0 (ptr == `RSW_CLK_LAST || ptr == `RSW_RAM_LAST)
            |=> ptr == ($past(ptr) == `RSW_CLK_LAST ? `RSW_CLK_FIRST : `RSW_RAM_FIRST))
        else $error("pointer did not wrap in block");

    ptr_step_a: assert property (s_byte_stored ##0 (ptr != `RSW_CLK_LAST && ptr != `RSW_RAM_LAST)
            |=> ptr == 8'($past(ptr) + 8'h01))
        else $error("pointer did not increment");

    // Read pointer follows the same block wrap as writes
    read_step_a: assert property (clk_en && rd_next |=> ptr == next_addr($past(ptr)))
        else $error("read pointer did not advance");

    stay_data_a: assert property (s_byte_stored ##0 cs_active |=> state == RSW_DATA)
        else $error("write command ended after one byte");

    read_load_a: assert property (s_addr_taken ##0 (rx_byte == `RSW_FLAGS_ADDR)
            |=> tx_sh == {2'b00, $past(pin_s[`RSW_PIN_OSC]), $past(flags)})
        else $error("read data not loaded from address");

    backup_refuse_a: assert property (clk_en && on_bk |=> state == RSW_IDLE ##0 !so_oe)
        else $error("serial access while on backup");

    partial_drop_a: assert property (clk_en && $past(clk_en) && !cs_active && !$past(cs_active)
            |-> bit_cnt == `RSW_BIT_ZERO && !wr_fire)
        else $error("partial byte kept after select release");

    clear_stamps_a: assert property (clk_en && stamp_clr |=>
            clk_regs[5'(`RSW_PD_MONTH_ADDR)] == `RSW_STAMP_RESET && !power_loss_flag)
        else $error("stamps not cleared with flag");

    keep_stamp_a: assert property (clk_en && pd_evt && power_loss_flag && !wr_fire
            |=> $stable(clk_regs[5'(`RSW_PD_DATE_ADDR)]) && power_loss_flag)
        else $error("stamp overwritten while flag set");

endmodule // rsw_spi_port
`default_nettype wire

// *** src/rsw_consts.svh ***
// Address map, field layouts and reset values of the serial write port
`ifndef RSW_CONSTS_SVH
`define RSW_CONSTS_SVH

// Block boundaries for the two separately wrapping regions
`define RSW_CLK_FIRST      8'h00
`define RSW_CLK_LAST       8'h1F
`define RSW_RAM_FIRST      8'h20
`define RSW_RAM_LAST       8'h5F

// Timestamp registers
`define RSW_PD_DATE_ADDR   8'h1A
`define RSW_PD_MONTH_ADDR  8'h1B
`define RSW_PU_DATE_ADDR   8'h1E
`define RSW_PU_MONTH_ADDR  8'h1F
`define RSW_STAMP_RESET    8'h00
`define RSW_DATE_MASK      8'h3F
`define RSW_MONTH_MASK     8'hFF
`define RSW_FULL_MASK      8'hFF
`define RSW_ZERO_BYTE      8'h00

// Weekday and power flags register
`define RSW_FLAGS_ADDR     8'h03
`define RSW_FLAGS_RESET    5'h00
`define RSW_OSC_BIT        5
`define RSW_LOSS_BIT       4
`define RSW_BKEN_BIT       3
`define RSW_WEEKDAY_MSB    2

// Instruction codes and byte framing
`define RSW_CMD_READ       8'h03
`define RSW_CMD_WRITE      8'h02
`define RSW_BIT_LAST       3'h7
`define RSW_BIT_ZERO       3'h0

// Synchronised pin vector: positions and reset value
`define RSW_PIN_CS         0
`define RSW_PIN_SCK        1
`define RSW_PIN_SI         2
`define RSW_PIN_BK         3
`define RSW_PIN_BP         4
`define RSW_PIN_OSC        5
`define RSW_PIN_RESET      6'h01

`endif

// *** src/rsw_pkg.sv ***
// Types shared by the serial write port
`default_nettype none
package rsw_pkg;

    typedef enum logic [2:0] {
        RSW_IDLE = 3'b000,
        RSW_CMD  = 3'b001,
        RSW_ADDR = 3'b010,
        RSW_DATA = 3'b011,
        RSW_SKIP = 3'b100
    } rsw_state_type;

    typedef struct packed {
        logic [1:0] unused_zero;
        logic [1:0] date_tens_digit;
        logic [3:0] date_ones_digit;
    } rsw_date_type;

    typedef struct packed {
        logic [2:0] weekday_field;
        logic       month_tens_bit;
        logic [3:0] month_ones_digit;
    } rsw_month_type;

    typedef struct packed {
        rsw_date_type  date;
        rsw_month_type month;
    } rsw_stamp_type;

endpackage
`default_nettype wire

// *** dv/rsw_host.sv ***
// SPI host model that frames commands on the port's select, clock and data pins
`default_nettype none
module rsw_host (
    input  wire logic ref_clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rxq[$];

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Read data is taken late in the high phase, so the port's synchroniser delay cannot decide it
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            sck <= 1'b0;
            si  <= tx[i];
            wait_clk(4);
            sck <= 1'b1;
            wait_clk(4);
            // A released output shows the inverse of its last bit, so a missing enable is caught
            rx[i] = so_oe ? so : !so;
        end
    endtask

    // A short last byte lets the bench abort a byte in mid-shift
    task automatic frame(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] data[$],
                         input int tail_bits);
        logic [7:0] rx;
        rxq.delete();
        cs_n <= 1'b0;
        wait_clk(4);
        xfer(cmd, 8, rx);
        xfer(addr, 8, rx);
        foreach (data[k]) begin
            xfer(data[k], (k == data.size() - 1 && tail_bits > 0) ? tail_bits : 8, rx);
            rxq.push_back(rx);
        end
        sck <= 1'b0;
        wait_clk(4);
        cs_n <= 1'b1;
        si   <= ~si;
        wait_clk(4);
    endtask
endmodule // rsw_host
`default_nettype wire

// *** dv/rsw_testbench.sv ***
// Self-checking bench of the serial register and scratch RAM port
`include "rsw_consts.svh"
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); end end
module testbench
    import rsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          ref_clk = 1'b0;
    logic          resetn;
    logic          clk_en;
    logic          cs_n;
    logic          sck;
    logic          si;
    logic          so;
    logic          so_oe;
    logic          on_backup;
    logic          backup_present;
    logic          osc_running;
    rsw_stamp_type now_stamp;
    logic          backup_input_enable;
    logic          power_loss_flag;
    int            failures = 0;
    int            total_checks = 0;
    int            seed;
    logic [7:0]    mem [0:255];
    logic [7:0]    q[$];
    logic [7:0]    a;

    always #12.5 ref_clk = ~ref_clk;

    rsw_spi_port rsw_spi_port_inst (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .cs_n(cs_n),
        .sck(sck), .si(si), .so(so), .so_oe(so_oe), .on_backup(on_backup), .backup_present(backup_present),
        .osc_running(osc_running), .now_stamp(now_stamp), .backup_input_enable(backup_input_enable),
        .power_loss_flag(power_loss_flag));

    rsw_host rsw_host_inst (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

    function automatic logic [7:0] next_addr(input logic [7:0] p);
        return (p == 8'h1F) ? 8'h00 : (p == 8'h5F) ? 8'h20 : p + 8'h01;
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] p);
        if (p > 8'h5F) return 8'h00;
        if (p == 8'h1A || p == 8'h1E) return mem[p] & 8'h3F;
        return mem[p];
    endfunction

    task automatic clk_wait(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a0, input logic [7:0] dq[$], input int tail);
        logic [7:0] p;
        p = a0;
        rsw_host_inst.frame(`RSW_CMD_WRITE, a0, dq, tail);
        foreach (dq[k]) begin
            if (k < dq.size() - 1 || tail == 0) mem[p] = dq[k];
            p = next_addr(p);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a0, input int n);
        logic [7:0] dq[$];
        logic [7:0] p;
        p = a0;
        for (int k = 0; k < n; k++) dq.push_back(8'h00);
        rsw_host_inst.frame(`RSW_CMD_READ, a0, dq, 0);
        for (int k = 0; k < n; k++) begin
            `CHK(rsw_host_inst.rxq[k], exp_rd(p))
            p = next_addr(p);
        end
    endtask

    // Every cycle also tries a RAM write while on backup, which must be refused
    task automatic power_cycle(input rsw_stamp_type dn, input rsw_stamp_type up);
        now_stamp <= dn;
        clk_wait(4);
        on_backup <= 1'b1;
        clk_wait(8);
        rsw_host_inst.frame(`RSW_CMD_WRITE, 8'h41, '{8'h77}, 0);
        now_stamp <= up;
        clk_wait(4);
        on_backup <= 1'b0;
        clk_wait(12);
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        failures++;
        end_sim();
    end

    initial begin
        seed = 32'h2A6C;
        resetn = 1'b0;
        clk_en = 1'b1;
        on_backup = 1'b0;
        backup_present = 1'b0;
        osc_running = 1'b0;
        now_stamp = '0;
        for (int k = 0; k < 32; k++) mem[k] = 8'h00;
        clk_wait(5);
        resetn <= 1'b1;
        clk_wait(6);
        `CHK({power_loss_flag, backup_input_enable}, 2'b00)
        rd_chk(8'h1A, 2);
        rd_chk(8'h1E, 2);
        wr(8'h1A, '{8'hFF, 8'hFF}, 0);
        rd_chk(8'h1A, 2);
        q = '{8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
        wr(8'h1E, q, 0);
        rd_chk(8'h1E, 4);
        wr(8'h5E, '{8'($random(seed)), 8'($random(seed)), 8'($random(seed))}, 0);
        rd_chk(8'h5E, 3);
        for (int i = 0; i < 6; i++) begin
            a = 8'h20 + 8'($random(seed) & 63);
            q = '{8'($random(seed)), 8'($random(seed))};
            wr(a, q, 0);
            rd_chk(a, 2);
        end
        wr(8'h60, '{8'hA5}, 0);
        rd_chk(8'h60, 1);
        wr(8'h40, '{8'h3C, 8'hC3}, 0);
        wr(8'h40, '{8'($random(seed)), 8'h5A}, 5);
        rd_chk(8'h40, 2);
        rsw_host_inst.frame(8'h05, 8'h40, '{8'h11}, 0);
        rd_chk(8'h40, 1);
        clk_en <= 1'b0;
        clk_wait(10);
        clk_en <= 1'b1;
        clk_wait(2);
        osc_running <= 1'b1;
        rsw_host_inst.frame(`RSW_CMD_WRITE, `RSW_FLAGS_ADDR, '{8'h1D}, 0);
        rsw_host_inst.frame(`RSW_CMD_READ, `RSW_FLAGS_ADDR, '{8'h00}, 0);
        `CHK(rsw_host_inst.rxq[0], 8'h2D)
        `CHK(backup_input_enable, 1'b1)
        backup_present <= 1'b1;
        power_cycle(16'h2552, 16'h31E9);
        `CHK(power_loss_flag, 1'b1)
        {mem[8'h1A], mem[8'h1B], mem[8'h1E], mem[8'h1F]} = 32'h2552_31E9;
        rd_chk(8'h1A, 2);
        rd_chk(8'h1E, 2);
        rd_chk(8'h40, 2);
        power_cycle(16'h0721, 16'h1342);
        rd_chk(8'h1A, 2);
        rd_chk(8'h1E, 2);
        rsw_host_inst.frame(`RSW_CMD_WRITE, `RSW_FLAGS_ADDR, '{8'h08}, 0);
        `CHK(power_loss_flag, 1'b0)
        {mem[8'h1A], mem[8'h1B], mem[8'h1E], mem[8'h1F]} = 32'h0;
        rd_chk(8'h1A, 2);
        rd_chk(8'h1E, 2);
        rsw_host_inst.frame(`RSW_CMD_WRITE, `RSW_FLAGS_ADDR, '{8'h00}, 0);
        power_cycle(16'h1111, 16'h2222);
        for (int k = 8'h20; k < 8'h60; k++) mem[k] = 8'h00;
        rd_chk(8'h40, 2);
        rd_chk(8'h1A, 2);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
